// ==== psm_params.svh ====
// Purpose: Constants of the power saving mode controller
// Assumes: Word-indexed Avalon-MM register map
// Notes:   Counts are in master clock cycles
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH

// Register word indices
`define PSM_ADDR_W        4
`define PSM_REG_CLKCTL    4'h0
`define PSM_REG_STATUS    4'h1

// Clock control register fields
`define PSM_OIE_BIT       0
`define PSM_SMS_BIT       1
`define PSM_CPX_LSB       2
`define PSM_CPX_MSB       3

// Opcodes seen on the decode port; the wait opcode value is arbitrary
`define PSM_OP_HALT       8'h8E
`define PSM_OP_WAIT       8'hA5

// Interrupt mask value forced on entry to wait, active halt or halt mode
`define PSM_MASK_ALL_ON   2'h2

// Wake eligibility per vector number (bit n = vector n)
`define PSM_WAKE_HALT     12'h0BC
`define PSM_WAKE_AHALT    12'h0BE
`define PSM_WAKE_WAIT     12'hFBE

// Oscillator restart delays in master clock cycles
`define PSM_CNT_W         13
`define PSM_DLY_SHORT     13'h0100
`define PSM_DLY_LONG      13'h1000

`endif

// ==== psm_pkg.sv ====
// Purpose: Types of the power saving mode controller
// Assumes: Constants come from psm_params.svh
// Notes:   One-hot mode encoding
package psm_pkg;

	typedef enum logic [7:0]
	{
		PSM_RUN       = 8'h01,
		PSM_SLOW      = 8'h02,
		PSM_WAIT      = 8'h04,
		PSM_SLOW_WAIT = 8'h08,
		PSM_ACT_HALT  = 8'h10,
		PSM_HALT      = 8'h20,
		PSM_STAB      = 8'h40,
		PSM_HALT_REST = 8'h80
	} psm_state_e;

	typedef struct packed
	{
		logic [3:0] cnt;
		logic       tick;
	} psm_div_s;

endpackage : psm_pkg

// ==== psm_div_if.sv ====
// Purpose: Carrier between mode controller and slow clock divider
// Assumes: Single clock domain
// Notes:   tick is a one-cycle enable at the divided rate
`timescale 1ns/1ps
interface psm_div_if;
	logic [1:0] sel;
	logic       run;
	logic       tick;

	modport ctrl (output sel, output run, input tick);
	modport div  (input sel, input run, output tick);
endinterface : psm_div_if

// ==== psm_divider.sv ====
// Purpose: Divides the master clock by 2, 4, 8 or 16 as an enable
// Assumes: sel stable while run is high
// Notes:   Counter restarts whenever run is low
`timescale 1ns/1ps
module psm_divider
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Control and tick
	psm_div_if.div   dv
);
	import psm_pkg::*;

	psm_div_s q;
	psm_div_s next_q;

	always_comb
	begin
		logic [3:0] last;
		last = 4'h0;
		next_q = q;
		unique case (dv.sel)
			2'h0: last = 4'h1;
			2'h1: last = 4'h3;
			2'h2: last = 4'h7;
			2'h3: last = 4'hF;
		endcase
		next_q.tick = 1'b0;
		if (!dv.run)
		begin
			next_q.cnt = 4'h0;
		end
		else if (q.cnt >= last)
		begin
			next_q.cnt  = 4'h0;
			next_q.tick = 1'b1;
		end
		else
		begin
			next_q.cnt = q.cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			q <= '0;
		else
			q <= next_q;
	end

	assign dv.tick = q.tick;

endmodule : psm_divider

// ==== psm_ctrl.sv ====
// Purpose: Power saving mode sequencer with clock gating controls
// Assumes: CPU and interrupt sources run on sys_clk
// Notes:   Clock gates are enables, registered in the same cycle as the mode
`timescale 1ns/1ps
`include "psm_params.svh"
module psm_ctrl
(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	// Avalon-MM slave
	input  wire logic [`PSM_ADDR_W-1:0]    avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	output      logic [31:0]               avs_readdata,
	output      logic                      avs_waitrequest,
	// CPU decode and condition code
	input  wire logic                      instr_valid,
	input  wire logic [7:0]                instr_opcode,
	input  wire logic [1:0]                svc_priority,
	input  wire logic                      cc_pop,
	output      logic [1:0]                cc_mask,
	// Interrupt sources, bit n is vector n
	input  wire logic [11:0]               irq_pend,
	// Reset pin seen while halted
	input  wire logic                      ext_reset_wake,
	// Option bits and watchdog
	input  wire logic                      watchdog_halt_option,
	input  wire logic                      delay_option,
	input  wire logic                      watchdog_enabled,
	output      logic                      watchdog_reset_req,
	// Clock controls
	output      logic                      cpu_clk_en,
	output      logic                      periph_clk_en,
	output      logic                      osc_enable,
	output      logic                      timebase_clk_en,
	// Wake report
	output      logic                      cpu_wake,
	output      logic                      wake_by_reset,
	output      logic [3:0]                wake_vector,
	output      psm_pkg::psm_state_e       mode
);
	import psm_pkg::*;

	typedef struct packed
	{
		psm_state_e             state;
		logic                   oscillator_interrupt_enable;
		logic                   slow_mode_select;
		logic [1:0]             slow_divider_select;
		logic [1:0]             mask;
		logic [1:0]             stack;
		logic [`PSM_CNT_W-1:0]  cnt;
		logic [`PSM_CNT_W-1:0]  guard;
		logic                   cause_rst;
		logic                   opt_taken;
		logic                   wdg_opt;
		logic                   long_dly;
		logic [1:0]             rsync;
		logic                   cpu_en;
		logic                   per_en;
		logic                   osc_en;
		logic                   tb_en;
		logic                   wake;
		logic                   wake_rst;
		logic [3:0]             wake_id;
		logic                   wdg_rst;
		logic                   waitreq;
		logic [31:0]            rdata;
	} psm_ctrl_s;

	psm_ctrl_s q;
	psm_ctrl_s next_q;

	psm_div_if div_bus ();

	psm_divider u_div
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.dv      (div_bus.div)
	);

	assign div_bus.sel = q.slow_divider_select;
	assign div_bus.run = (q.state == PSM_SLOW) ||
	                     (q.state == PSM_SLOW_WAIT);

	// Lowest vector number has highest priority
	function automatic logic [3:0] first_pend(input logic [11:0] p);
		logic [3:0] id;
		id = 4'h0;
		for (int i = 11; i >= 0; i--)
			if (p[i])
				id = 4'(i);
		return id;
	endfunction : first_pend

	function automatic logic [`PSM_CNT_W-1:0] dly_load(input logic lng);
		return lng ? (`PSM_DLY_LONG - `PSM_CNT_W'h1)
		           : (`PSM_DLY_SHORT - `PSM_CNT_W'h1);
	endfunction : dly_load

	function automatic psm_state_e run_state(input logic slow);
		return slow ? PSM_SLOW : PSM_RUN;
	endfunction : run_state

	always_comb
	begin
		logic       rst_wake;
		logic       svc;
		logic       is_halt;
		logic       is_wait;
		logic [11:0] wk_wait;
		logic [11:0] wk_ahalt;
		logic [11:0] wk_halt;
		rst_wake = 1'b0;
		svc      = 1'b0;
		is_halt  = 1'b0;
		is_wait  = 1'b0;
		wk_wait  = 12'h000;
		wk_ahalt = 12'h000;
		wk_halt  = 12'h000;
		next_q = q;
		next_q.wake    = 1'b0;
		next_q.wdg_rst = 1'b0;

		// Reset pin comes from outside; two stages before use
		next_q.rsync = {q.rsync[0], ext_reset_wake};
		rst_wake = q.rsync[1];

		// Option bits caught once after reset release
		if (!q.opt_taken)
		begin
			next_q.opt_taken = 1'b1;
			next_q.wdg_opt   = watchdog_halt_option;
			next_q.long_dly  = delay_option;
		end

		// Bus: first cycle loads read data, second completes
		next_q.waitreq = 1'b1;
		if ((avs_read || avs_write) && q.waitreq)
		begin
			next_q.waitreq = 1'b0;
			unique case (avs_address)
				`PSM_REG_CLKCTL:
					next_q.rdata = {28'h0, q.slow_divider_select, q.slow_mode_select, q.oscillator_interrupt_enable};
				`PSM_REG_STATUS:
					next_q.rdata = {21'h0, (q.guard != '0),
					                q.mask, q.state};
				default:
					next_q.rdata = 32'h0;
			endcase
		end
		if (avs_write && !q.waitreq &&
		    avs_address == `PSM_REG_CLKCTL)
		begin
			next_q.oscillator_interrupt_enable = avs_writedata[`PSM_OIE_BIT];
			next_q.slow_mode_select = avs_writedata[`PSM_SMS_BIT];
			next_q.slow_divider_select = avs_writedata[`PSM_CPX_MSB:`PSM_CPX_LSB];
		end

		if (cc_pop)
			next_q.mask = q.stack;
		if (q.guard != '0)
			next_q.guard = q.guard - `PSM_CNT_W'h1;
		if (q.cnt != '0)
			next_q.cnt = q.cnt - `PSM_CNT_W'h1;

		wk_wait  = irq_pend & `PSM_WAKE_WAIT;
		wk_ahalt = irq_pend & `PSM_WAKE_AHALT;
		wk_halt  = irq_pend & `PSM_WAKE_HALT;
		is_halt  = instr_valid && instr_opcode == `PSM_OP_HALT;
		is_wait  = instr_valid && instr_opcode == `PSM_OP_WAIT;

		unique case (q.state)
			PSM_RUN, PSM_SLOW:
			begin
				next_q.state = run_state(next_q.slow_mode_select);
				if (q.guard != '0 && !next_q.oscillator_interrupt_enable)
				begin
					next_q.state = PSM_HALT_REST;
				end
				else if (is_wait)
				begin
					next_q.mask  = `PSM_MASK_ALL_ON;
					next_q.state = q.slow_mode_select ? PSM_SLOW_WAIT
					                     : PSM_WAIT;
				end
				else if (is_halt && q.oscillator_interrupt_enable)
				begin
					// Timebase bounds the stay, so no watchdog reset
					next_q.mask  = `PSM_MASK_ALL_ON;
					next_q.state = PSM_ACT_HALT;
				end
				else if (is_halt && watchdog_enabled && !q.wdg_opt)
				begin
					next_q.wdg_rst = 1'b1;
				end
				else if (is_halt)
				begin
					next_q.mask  = `PSM_MASK_ALL_ON;
					next_q.state = PSM_HALT;
				end
			end
			PSM_WAIT, PSM_SLOW_WAIT:
			begin
				if (rst_wake || wk_wait != 12'h000)
				begin
					svc = 1'b1;
					next_q.cause_rst = rst_wake;
					next_q.state = run_state(q.slow_mode_select);
				end
			end
			PSM_ACT_HALT:
			begin
				if (rst_wake)
				begin
					next_q.cause_rst = 1'b1;
					next_q.cnt   = dly_load(q.long_dly);
					next_q.state = PSM_STAB;
				end
				else if (wk_ahalt != 12'h000)
				begin
					// Pending at entry wakes at once
					svc = 1'b1;
					next_q.cause_rst = 1'b0;
					next_q.guard = dly_load(q.long_dly);
					next_q.state = run_state(q.slow_mode_select);
				end
			end
			PSM_HALT:
			begin
				if (rst_wake || wk_halt != 12'h000)
				begin
					next_q.cause_rst = rst_wake;
					next_q.cnt   = dly_load(q.long_dly);
					next_q.state = PSM_STAB;
				end
			end
			PSM_STAB:
			begin
				if (q.cnt == '0)
				begin
					svc = 1'b1;
					next_q.state = run_state(q.slow_mode_select);
				end
			end
			PSM_HALT_REST:
			begin
				if (q.guard == '0)
					next_q.state = run_state(q.slow_mode_select);
			end
			default:
				next_q.state = PSM_RUN;
		endcase

		// Interrupt service start: stack the mask, load routine priority
		if (svc)
		begin
			next_q.wake     = 1'b1;
			next_q.wake_rst = next_q.cause_rst;
			next_q.wake_id  = next_q.cause_rst ? 4'h0
			                  : first_pend(wk_wait);
			if (!next_q.cause_rst)
			begin
				next_q.stack = q.mask;
				next_q.mask  = svc_priority;
			end
		end

		// Gates follow the next mode, and the divider tick in the slow modes
		unique case (next_q.state)
			PSM_RUN:
			begin
				next_q.cpu_en = 1'b1;
				next_q.per_en = 1'b1;
			end
			PSM_SLOW:
			begin
				next_q.cpu_en = div_bus.tick;
				next_q.per_en = div_bus.tick;
			end
			PSM_WAIT:
			begin
				next_q.cpu_en = 1'b0;
				next_q.per_en = 1'b1;
			end
			PSM_SLOW_WAIT:
			begin
				next_q.cpu_en = 1'b0;
				next_q.per_en = div_bus.tick;
			end
			default:
			begin
				next_q.cpu_en = 1'b0;
				next_q.per_en = 1'b0;
			end
		endcase
		// Oscillator off only in HALT and in the rest of the active-halt guard delay
		next_q.osc_en = !(next_q.state == PSM_HALT ||
		                  next_q.state == PSM_HALT_REST);
		// Restarting oscillator is not trusted for the timebase
		next_q.tb_en  = next_q.osc_en &&
		                next_q.state != PSM_STAB;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			q         <= '0;
			q.state   <= PSM_RUN;
			q.mask    <= `PSM_MASK_ALL_ON;
			q.cpu_en  <= 1'b1;
			q.per_en  <= 1'b1;
			q.osc_en  <= 1'b1;
			q.tb_en   <= 1'b1;
			q.waitreq <= 1'b1;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign avs_readdata       = q.rdata;
	assign avs_waitrequest    = q.waitreq;
	assign cc_mask            = q.mask;
	assign watchdog_reset_req = q.wdg_rst;
	assign cpu_clk_en         = q.cpu_en;
	assign periph_clk_en      = q.per_en;
	assign osc_enable         = q.osc_en;
	assign timebase_clk_en    = q.tb_en;
	assign cpu_wake           = q.wake;
	assign wake_by_reset      = q.wake_rst;
	assign wake_vector        = q.wake_id;
	assign mode               = q.state;

endmodule : psm_ctrl

// ==== psm_ctrl_monitor.sv ====
// Purpose: Port assertions for the power saving mode controller
// Assumes: One clock domain, delay strap held constant
// Notes:   Bound to psm_ctrl below the module
`timescale 1ns/1ps
`include "psm_params.svh"
module psm_ctrl_monitor
	import psm_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// Bus and decode
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        instr_valid,
	input wire logic [7:0]  instr_opcode,
	input wire logic [1:0]  svc_priority,
	input wire logic [11:0] irq_pend,
	input wire logic        delay_option,
	// Controls and report
	input wire logic        watchdog_reset_req,
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic        osc_enable,
	input wire logic        timebase_clk_en,
	input wire logic        cpu_wake,
	input wire logic        wake_by_reset,
	input wire logic [1:0]  cc_mask,
	input psm_state_e       mode
);
	logic [12:0] stab_len;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Length of the current stabilisation stretch
	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			stab_len <= 13'h0;
		else
			stab_len <= (mode == PSM_STAB) ? stab_len + 13'h1 : 13'h0;
	property p_start;
		$fell(reset) |-> mode == PSM_RUN && cc_mask == `PSM_MASK_ALL_ON;
	endproperty
	a_start: assert property (p_start) else $error("not RUN");
	property p_wait;
		instr_valid && instr_opcode == `PSM_OP_WAIT && mode == PSM_RUN
		|=> mode == PSM_WAIT && cc_mask == `PSM_MASK_ALL_ON;
	endproperty
	a_wait: assert property (p_wait) else $error("bad wait");
	property p_swait;
		instr_valid && instr_opcode == `PSM_OP_WAIT && mode == PSM_SLOW
		|=> mode == PSM_SLOW_WAIT;
	endproperty
	a_swait: assert property (p_swait) else $error("bad slow wait");
	property p_halt;
		instr_valid && instr_opcode == `PSM_OP_HALT && mode == PSM_RUN |=>
		(mode inside {PSM_ACT_HALT, PSM_HALT} && cc_mask == `PSM_MASK_ALL_ON)
		|| (watchdog_reset_req && mode == PSM_RUN);
	endproperty
	a_halt: assert property (p_halt) else $error("bad halt");
	property p_aexit;
		mode == PSM_ACT_HALT && (irq_pend & `PSM_WAKE_AHALT) != 12'h0
		|=> cpu_wake && !wake_by_reset && mode inside {PSM_RUN, PSM_SLOW};
	endproperty
	a_aexit: assert property (p_aexit) else $error("slow exit");
	property p_agate;
		(mode == PSM_ACT_HALT) [*2] |-> osc_enable && timebase_clk_en
		&& !cpu_clk_en && !periph_clk_en && !watchdog_reset_req;
	endproperty
	a_agate: assert property (p_agate) else $error("bad gates");
	property p_hgate;
		(mode == PSM_HALT) [*2] |-> !(osc_enable || timebase_clk_en
		|| cpu_clk_en || periph_clk_en);
	endproperty
	a_hgate: assert property (p_hgate) else $error("clock on");
	property p_stab;
		$fell(mode == PSM_STAB) |-> cpu_wake && stab_len ==
		(delay_option ? `PSM_DLY_LONG : `PSM_DLY_SHORT);
	endproperty
	a_stab: assert property (p_stab) else $error("bad delay");
	property p_bus;
		(avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bad wait state");
	property p_svc;
		cpu_wake && !wake_by_reset |-> cc_mask == $past(svc_priority);
	endproperty
	a_svc: assert property (p_svc) else $error("bad mask");
endmodule : psm_ctrl_monitor

bind psm_ctrl psm_ctrl_monitor u_mon (.sys_clk, .reset, .avs_read,
	.avs_write, .avs_waitrequest, .instr_valid, .instr_opcode,
	.svc_priority, .irq_pend, .delay_option, .watchdog_reset_req,
	.cpu_clk_en, .periph_clk_en, .osc_enable, .timebase_clk_en,
	.cpu_wake, .wake_by_reset, .cc_mask, .mode);

// ==== psm_irq_model.sv ====
// Purpose: Interrupt sources with request latches
// Assumes: Latch cleared when its vector is serviced
// Notes:   Stale requests stay until software clears them
`timescale 1ns/1ps
module psm_irq_model
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// Events and clears from software
	input wire logic [11:0] irq_event,
	input wire logic [11:0] irq_clear,
	// Service report
	input wire logic        cpu_wake,
	input wire logic        wake_by_reset,
	input wire logic [3:0]  wake_vector,
	// Requests
	output logic [11:0]     irq_pend
);
	logic [11:0] served;
	assign served = (cpu_wake && !wake_by_reset) ? 12'h1 << wake_vector
		: 12'h0;
	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			irq_pend <= 12'h0;
		else
			irq_pend <= (irq_pend | irq_event) & ~served & ~irq_clear;
endmodule : psm_irq_model

// ==== test_power_saving_mode_controller.sv ====
// Purpose: Self-checking bench of the mode controller
// Assumes: Short delay strap, long one after the mid-run reset
// Notes:   Every wake source waits under a bound
`timescale 1ns/1ps
`include "psm_params.svh"
`define CHK(s, e, a) begin check_count++; if ((a) !== (e)) begin \
	mismatches++; $display("wrong value %s exp %h got %h", s, e, a); end end
module test_power_saving_mode_controller;
	import psm_pkg::*;
	logic sys_clk = 0, reset = 1, avs_read = 0, avs_write = 0;
	logic [3:0] avs_address = 0, wake_vector;
	logic [31:0] avs_writedata = 0, avs_readdata, q;
	logic avs_waitrequest, instr_valid = 0, cc_pop = 0, ext_reset_wake = 0;
	logic [7:0] instr_opcode = 0;
	logic [1:0] svc_priority = 0, cc_mask, sel;
	logic [11:0] irq_pend, irq_event = 0, irq_clear = 0;
	logic watchdog_halt_option = 1, watchdog_enabled = 0, delay_option = 0;
	logic watchdog_reset_req, cpu_clk_en, periph_clk_en, osc_enable;
	logic timebase_clk_en, cpu_wake, wake_by_reset;
	psm_state_e mode;
	int mismatches = 0, check_count = 0, n, i, v;
	always #25 sys_clk = ~sys_clk;
	psm_ctrl uut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .instr_valid,
		.instr_opcode, .svc_priority, .cc_pop, .cc_mask, .irq_pend,
		.ext_reset_wake, .watchdog_halt_option, .delay_option,
		.watchdog_enabled, .watchdog_reset_req, .cpu_clk_en, .periph_clk_en,
		.osc_enable, .timebase_clk_en, .cpu_wake, .wake_by_reset,
		.wake_vector, .mode);
	psm_irq_model u_irq (.sys_clk, .reset, .irq_event, .irq_clear,
		.cpu_wake, .wake_by_reset, .wake_vector, .irq_pend);
	function automatic logic may_wake(input int m, input int v);
		// m: 0 wait, 1 active halt, 2 halt
		may_wake = (v >= 2 && v <= 5) || v == 7 || (v == 1 && m < 2)
			|| (v >= 8 && v <= 11 && m == 0);
	endfunction : may_wake
	task results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task step(input int c);
		repeat (c) @(posedge sys_clk);
	endtask : step
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, a, d};
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 20);
		q = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
		if (i == 20)
		begin
			mismatches++;
			results();
		end
	endtask : bus
	task op(input logic [7:0] code);
		@(posedge sys_clk);
		{instr_valid, instr_opcode} <= {1'b1, code};
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		@(negedge sys_clk);
	endtask : op
	task wake(input logic [11:0] ev);
		@(posedge sys_clk);
		irq_event <= ev;
		@(posedge sys_clk);
		irq_event <= 12'h0;
		for (n = 0; n < 5000 && cpu_wake !== 1'b1; n++)
			@(negedge sys_clk);
		if (n == 5000)
		begin
			mismatches++;
			results();
		end
	endtask : wake
	initial
	begin
		void'($urandom(32'h4ec0));
		step(4);
		reset <= 1'b0;
		step(2);
		@(negedge sys_clk);
		`CHK("mode", PSM_RUN, mode)
		`CHK("clocks", 1'b1, cpu_clk_en & periph_clk_en & osc_enable)
		bus(1'b0, `PSM_REG_STATUS, 32'h0);
		`CHK("status", 32'h0000_0201, q)
		bus(1'b1, 4'hF, 32'hFFFF_FFFF);
		bus(1'b0, 4'hF, 32'h0);
		`CHK("unmapped", 32'h0, q)
		$display("test reset done");
		sel = 2'($urandom);
		svc_priority <= 2'($urandom);
		bus(1'b1, `PSM_REG_CLKCTL, {28'h0, sel, 2'b10});
		step(4);
		for (i = 0, n = 0; i < 64; i++)
		begin
			@(negedge sys_clk);
			n += cpu_clk_en;
		end
		`CHK("slow_rate", 64 >> (sel + 1), n)
		op(`PSM_OP_WAIT);
		`CHK("mode", PSM_SLOW_WAIT, mode)
		wake(12'h200);
		`CHK("vector", 4'h9, wake_vector)
		`CHK("svc_mask", svc_priority, cc_mask)
		@(posedge sys_clk) cc_pop <= 1'b1;
		@(posedge sys_clk) cc_pop <= 1'b0;
		@(negedge sys_clk);
		`CHK("pop_mask", 2'h2, cc_mask)
		`CHK("mode", PSM_SLOW, mode)
		bus(1'b1, `PSM_REG_CLKCTL, 32'h0);
		$display("test slow done");
		for (v = 1; v < 12; v++)
		begin
			if (v == 6)
				continue;
			svc_priority <= 2'($urandom);
			op(`PSM_OP_WAIT);
			`CHK("wait_mask", 2'h2, cc_mask)
			step(2);
			@(negedge sys_clk);
			`CHK("wait_gate", 2'b01, {cpu_clk_en, periph_clk_en})
			wake(12'h1 << v);
			`CHK("vector", 4'(v), wake_vector)
			step(3);
		end
		$display("test wait done");
		bus(1'b1, `PSM_REG_CLKCTL, 32'h1);
		for (v = 1; v < 12; v++)
		begin
			if (v == 6)
				continue;
			op(`PSM_OP_HALT);
			`CHK("mode", PSM_ACT_HALT, mode)
			if (!may_wake(1, v))
			begin
				@(posedge sys_clk) irq_event <= 12'h1 << v;
				@(posedge sys_clk) irq_event <= 12'h0;
				step(20);
				@(negedge sys_clk);
				`CHK("no_wake", PSM_ACT_HALT, mode)
				@(posedge sys_clk) irq_clear <= 12'h1 << v;
				@(posedge sys_clk) irq_clear <= 12'h0;
				wake(12'h4);
			end
			else
				wake(12'h1 << v);
			// Pending seen at one edge, pulse shown at the next
			`CHK("awake", 2, n)
			`CHK("ah_vector", may_wake(1, v) ? 4'(v) : 4'h2, wake_vector)
			step(260);
		end
		irq_event <= 12'h10;
		@(posedge sys_clk) irq_event <= 12'h0;
		op(`PSM_OP_HALT);
		@(negedge sys_clk);
		`CHK("pend_wake", 5'h14, {cpu_wake, wake_vector})
		bus(1'b1, `PSM_REG_CLKCTL, 32'h0);
		@(negedge sys_clk);
		`CHK("guard", PSM_HALT_REST, mode)
		for (n = 0; n < 300 && mode !== PSM_RUN; n++)
			@(negedge sys_clk);
		`CHK("guard_len", 1'b1, n < 256)
		if (n == 300)
			results();
		$display("test active halt done");
		op(`PSM_OP_HALT);
		`CHK("mode", PSM_HALT, mode)
		@(posedge sys_clk) irq_event <= 12'h102;
		@(posedge sys_clk) irq_event <= 12'h0;
		step(20);
		@(negedge sys_clk);
		`CHK("halt_stay", 2'b00, {mode == PSM_HALT, osc_enable} ^ 2'b10)
		@(posedge sys_clk) irq_clear <= 12'h102;
		@(posedge sys_clk) irq_clear <= 12'h0;
		wake(12'h8);
		`CHK("halt_exit", 5'h13, {n >= 256, wake_vector})
		op(`PSM_OP_HALT);
		@(posedge sys_clk) ext_reset_wake <= 1'b1;
		wake(12'h0);
		@(posedge sys_clk) ext_reset_wake <= 1'b0;
		`CHK("pin_wake", 1'b1, wake_by_reset && n >= 256)
		$display("test halt done");
		@(posedge sys_clk);
		{reset, watchdog_halt_option, watchdog_enabled} <= 3'b101;
		// Long restart delay strap from here on
		delay_option <= 1'b1;
		step(2);
		reset <= 1'b0;
		step(2);
		@(negedge sys_clk);
		`CHK("mode", PSM_RUN, mode)
		bus(1'b1, `PSM_REG_CLKCTL, 32'h0);
		op(`PSM_OP_HALT);
		`CHK("wdg_reset", 2'b11, {watchdog_reset_req, mode == PSM_RUN})
		bus(1'b1, `PSM_REG_CLKCTL, 32'h1);
		op(`PSM_OP_HALT);
		step(10);
		wake(12'h2);
		`CHK("timebase", 4'h1, wake_vector)
		op(`PSM_OP_HALT);
		@(posedge sys_clk) ext_reset_wake <= 1'b1;
		wake(12'h0);
		@(posedge sys_clk) ext_reset_wake <= 1'b0;
		`CHK("long_delay", 1'b1, wake_by_reset && n >= 4096)
		$display("test watchdog done");
		results();
	end
endmodule : test_power_saving_mode_controller
